// ==== hw/sapi_pkg.sv ====
// Constants and carrier types of the converter control block.
// Assumes a 100 MHz clk; all pin inputs except comparator_high come from the host domain.
package sapi_pkg;

    localparam int          SAPI_BITS         = 12;
    localparam int          SAPI_CLK_MHZ      = 100;
    localparam int          SAPI_STEP_NS      = 120;
    localparam int          SAPI_WAKE_NS      = 350;
    localparam int          SAPI_STEP_CYC     = (SAPI_STEP_NS * SAPI_CLK_MHZ + 999) / 1000;
    localparam int          SAPI_WAKE_CYC     = (SAPI_WAKE_NS * SAPI_CLK_MHZ + 999) / 1000;
    localparam logic [11:0] SAPI_RESULT_RESET = 12'h000;
    localparam logic [11:0] SAPI_MSB_MASK     = 12'h800;
    localparam logic [11:0] SAPI_HALF_SCALE   = 12'h800;
    localparam logic [3:0]  SAPI_LAST_BIT     = 4'h0;
    localparam logic [3:0]  SAPI_FIRST_BIT    = 4'hb;
    localparam logic [7:0]  SAPI_CNT_ZERO     = 8'h00;

    typedef enum logic [1:0] {
        SAPI_IDLE  = 2'b00,
        SAPI_CONV  = 2'b01,
        SAPI_DONE  = 2'b10
    } sapi_phase_type;

    // Host strobe and level pins, raw or after synchronisation
    typedef struct packed {
        logic select_n;
        logic conversion_start_n;
        logic read_n;
        logic power_down_n;
        logic bipolar;
    } sapi_pins_type;

endpackage

// ==== hw/sapi_sync.sv ====
// Two-flop synchroniser for a bundle of host pins.
// Assumes an active-low asynchronous reset already released in step with clk.
`timescale 1ns/1ps
module sapi_sync
    import sapi_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst_n,
    input  wire sapi_pins_type raw,
    output sapi_pins_type      synced
);

    // Idle level: strobes high, power up, unipolar
    localparam sapi_pins_type IDLE_PINS = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

    sapi_pins_type stage1;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= IDLE_PINS;
            synced <= IDLE_PINS;
        end else begin
            stage1 <= raw;
            synced <= stage1;
        end
    end

endmodule

// ==== hw/sapi_top.sv ====
// Conversion control: start, lock-out, bit stepping, result latch, drivers.
// Assumes comparator_high is the analog comparator output for the current trial word.
`timescale 1ns/1ps
module sapi_top
    import sapi_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        select_n,
    input  wire logic        conversion_start_n,
    input  wire logic        read_n,
    input  wire logic        power_down_n,
    input  wire logic        bipolar,
    input  wire logic        comparator_high,
    output logic [11:0]      trial_word,
    output logic [11:0]      result_lines_out,
    output logic [11:0]      result_lines_oe,
    output logic             busy_n
);

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic rst_meta;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    sapi_pins_type raw_pins;
    sapi_pins_type pins;

    assign raw_pins = '{select_n, conversion_start_n, read_n, power_down_n, bipolar};

    sapi_sync u_sync (
        .clk    (clk),
        .rst_n  (rst_sync_n),
        .raw    (raw_pins),
        .synced (pins)
    );

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        sapi_phase_type phase;
        logic           start_prev;
        logic [11:0]    sar;
        logic [11:0]    mask;
        logic [3:0]     bit_idx;
        logic [7:0]     step_cnt;
        logic [7:0]     wake_cnt;
        logic [11:0]    latch;
        logic [11:0]    out;
        logic [11:0]    oe;
        logic           busy_n;
    } sapi_state_type;

    sapi_state_type st;
    sapi_state_type next_st;
    logic           start_fall;
    logic           awake;
    logic           start_ok;
    logic           step_done;
    logic           last_bit;
    logic           result_shown;
    logic [11:0]    lower_bit;
    logic [11:0]    coded;
    logic [11:0]    line_drive;

    // ****************************************************************
    // Reset value
    // ****************************************************************
    // Start edge detector rests at the idle pin level so reset makes no false edge
    localparam sapi_state_type SAPI_ST_RESET = '{
        phase:      SAPI_IDLE,
        start_prev: 1'b1,
        sar:        SAPI_RESULT_RESET,
        mask:       SAPI_RESULT_RESET,
        bit_idx:    SAPI_LAST_BIT,
        step_cnt:   SAPI_CNT_ZERO,
        wake_cnt:   8'(SAPI_WAKE_CYC),
        latch:      SAPI_RESULT_RESET,
        out:        SAPI_RESULT_RESET,
        oe:         {SAPI_BITS{1'b0}},
        busy_n:     1'b1
    };

    // ****************************************************************
    // Result coding
    // ****************************************************************
    function automatic logic [11:0] code_result(
        input logic [11:0] word,
        input logic        two_comp
    );
        // Two's complement is the offset binary word with its top bit flipped
        if (two_comp) begin
            return word ^ SAPI_HALF_SCALE;
        end else begin
            return word;
        end
    endfunction

    // ****************************************************************
    // Line enables
    // ****************************************************************
    // One enable per result line, all from the same selected-read decode
    for (genvar b = 0; b < SAPI_BITS; b++) begin : g_line
        assign line_drive[b] = ~pins.read_n & ~pins.select_n;
    end

    // ****************************************************************
    // Control decode
    // ****************************************************************
    assign start_fall   = st.start_prev & ~pins.conversion_start_n;
    assign awake        = pins.power_down_n && (st.wake_cnt == SAPI_CNT_ZERO);
    // Busy must be back high first, else a start in the release gap would run unflagged
    assign start_ok     = start_fall && !pins.select_n && awake && st.busy_n;
    assign step_done    = (st.step_cnt == SAPI_CNT_ZERO);
    assign last_bit     = (st.bit_idx == SAPI_LAST_BIT);
    assign result_shown = (st.out == st.latch);
    assign lower_bit    = st.mask >> 1;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_st            = st;
        next_st.start_prev = pins.conversion_start_n;
        coded              = SAPI_RESULT_RESET;

        // ************************************************************
        // Wake-up timer
        // ************************************************************
        // Restarts whenever power-down is asserted
        if (!pins.power_down_n) begin
            next_st.wake_cnt = 8'(SAPI_WAKE_CYC);
        end else if (st.wake_cnt != SAPI_CNT_ZERO) begin
            next_st.wake_cnt = st.wake_cnt - 8'h01;
        end

        // ************************************************************
        // Conversion sequencer
        // ************************************************************
        case (st.phase)
            SAPI_IDLE: begin
                // Starts only while idle, selected and powered up
                if (start_ok) begin
                    next_st.phase    = SAPI_CONV;
                    next_st.sar      = SAPI_MSB_MASK;
                    next_st.mask     = SAPI_MSB_MASK;
                    next_st.bit_idx  = SAPI_FIRST_BIT;
                    next_st.step_cnt = 8'(SAPI_STEP_CYC - 1);
                    next_st.busy_n   = 1'b0;
                end
            end
            SAPI_CONV: begin
                // Further start edges are not looked at here
                if (!step_done) begin
                    next_st.step_cnt = st.step_cnt - 8'h01;
                end else begin
                    // Comparator is read at step end, once the trial word has settled
                    // Keep or drop the trial bit, then try the next lower one
                    next_st.sar = comparator_high ? (st.sar & ~st.mask) : st.sar;
                    if (last_bit) begin
                        next_st.phase = SAPI_DONE;
                    end else begin
                        next_st.mask     = lower_bit;
                        next_st.sar      = next_st.sar | lower_bit;
                        next_st.bit_idx  = st.bit_idx - 4'h1;
                        next_st.step_cnt = 8'(SAPI_STEP_CYC - 1);
                    end
                end
            end
            SAPI_DONE: begin
                // Unipolar straight binary; bipolar flips the MSB to two's complement
                coded          = code_result(st.sar, pins.bipolar);
                next_st.latch  = coded;
                next_st.phase  = SAPI_IDLE;
            end
            default: begin
                next_st.phase  = SAPI_IDLE;
                next_st.busy_n = 1'b1;
            end
        endcase

        // ************************************************************
        // Busy release and drivers
        // ************************************************************
        // Busy rises one cycle after the driven result matches the latch, so the data is already out
        if (st.phase == SAPI_IDLE && !st.busy_n && result_shown) begin
            next_st.busy_n = 1'b1;
        end
        next_st.out = st.latch;
        next_st.oe = line_drive;
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st <= SAPI_ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign trial_word       = st.sar;
    assign result_lines_out = st.out;
    assign result_lines_oe  = st.oe;
    assign busy_n           = st.busy_n;

endmodule

// ==== tb/sapi_analog_model.sv ====
// Comparator stand-in for an analog input held as a code in vin.
// Assumes trial_word is the converter's current trial code.
`timescale 1ns/1ps
module sapi_analog_model (
    input  wire logic [11:0] trial_word,
    input  wire logic [11:0] vin,
    output logic             comparator_high
);
    // Drop the trial bit when the trial code lies above the input
    assign comparator_high = (trial_word > vin);
endmodule

// ==== tb/sapi_monitor.sv ====
// Port checker of the converter control block.
// Assumes a 100 MHz clk and rst_n active low.
`timescale 1ns/1ps
module sapi_monitor (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        select_n,
    input wire logic        conversion_start_n,
    input wire logic        read_n,
    input wire logic        power_down_n,
    input wire logic [11:0] trial_word,
    input wire logic [11:0] result_lines_out,
    input wire logic [11:0] result_lines_oe,
    input wire logic        busy_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_oe_float: assert property ((read_n | select_n)[*6] |-> result_lines_oe == 12'h000)
        else $error("drivers on while not read");
    a_oe_drive: assert property ((!read_n && !select_n)[*6] |-> result_lines_oe == 12'hfff)
        else $error("drivers off while read");
    a_select_gate: assert property (select_n[*8] ##0 busy_n |=> busy_n)
        else $error("start taken while deselected");
    a_power_gate: assert property (!power_down_n[*8] ##0 busy_n |=> busy_n)
        else $error("start taken while powered down");
    a_busy_min: assert property ($fell(busy_n) |-> ##140 !busy_n)
        else $error("conversion ended early");
    a_busy_max: assert property ($fell(busy_n) |-> ##[140:160] busy_n)
        else $error("conversion too long");
    a_msb_first: assert property ($fell(busy_n) |-> trial_word == 12'h800
        ##1 (trial_word[10:0] == 11'h000)[*8])
        else $error("first trial word wrong");
    a_latch_first: assert property ($rose(busy_n) |-> $stable(result_lines_out))
        else $error("result changed with busy rise");
endmodule
bind sapi_top sapi_monitor sapi_monitor_i (.clk(clk), .rst_n(rst_n), .select_n(select_n),
    .conversion_start_n(conversion_start_n), .read_n(read_n), .power_down_n(power_down_n),
    .trial_word(trial_word), .result_lines_out(result_lines_out),
    .result_lines_oe(result_lines_oe), .busy_n(busy_n));

// ==== tb/sapi_top_tb.sv ====
// Self-checking bench of the converter control block.
// Assumes the analog model answers the trial words.
`timescale 1ns/1ps
module sapi_top_tb;
    logic        clk, rst_n, select_n, conversion_start_n, read_n, power_down_n, bipolar;
    logic        comparator_high, busy_n;
    logic [11:0] trial_word, result_lines_out, result_lines_oe, vin, expq[$];
    logic [31:0] seed = 32'ha9374fb2;
    int          n_mismatch = 0, compares = 0, cycles = 0;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    sapi_top sapi_top_i (.clk(clk), .rst_n(rst_n), .select_n(select_n),
        .conversion_start_n(conversion_start_n), .read_n(read_n), .power_down_n(power_down_n),
        .bipolar(bipolar), .comparator_high(comparator_high), .trial_word(trial_word),
        .result_lines_out(result_lines_out), .result_lines_oe(result_lines_oe), .busy_n(busy_n));
    sapi_analog_model sapi_analog_model_i (.trial_word(trial_word), .vin(vin),
        .comparator_high(comparator_high));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_busy(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_drive(input logic [11:0] got, input logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic convert(input logic [11:0] v, input logic bip, sel, pd);
        vin <= v;
        bipolar <= bip;
        select_n <= sel;
        power_down_n <= pd;
        if (!sel && pd) expq.push_back(bip ? v ^ sapi_pkg::SAPI_HALF_SCALE : v);
        repeat (40) @(posedge clk);
        // Second pulse lands mid-conversion and must be ignored
        repeat (2) begin
            conversion_start_n <= 1'b0;
            repeat (5) @(posedge clk);
            conversion_start_n <= 1'b1;
            repeat (30) @(posedge clk);
        end
        check_busy(busy_n, sel | !pd);
        while (busy_n !== 1'b1) @(posedge clk);
        repeat (25) @(posedge clk);
        check_busy(busy_n, 1'b1);
    endtask
    always @(posedge busy_n) if (expq.size() > 0) check(result_lines_out, expq.pop_front());
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            tally_and_finish;
        end
    end
    initial begin
        rst_n = 1'b0;
        {select_n, conversion_start_n, read_n, power_down_n, bipolar} = 5'b11110;
        vin = 12'h000;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        convert(12'h000, 1'b0, 1'b0, 1'b1);
        convert(12'hfff, 1'b0, 1'b0, 1'b1);
        convert(12'h800, 1'b1, 1'b0, 1'b1);
        convert(12'h7ff, 1'b1, 1'b0, 1'b1);
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            convert(seed[11:0], seed[12], 1'b0, 1'b1);
        end
        convert(12'h555, 1'b0, 1'b1, 1'b1);
        convert(12'h555, 1'b0, 1'b0, 1'b0);
        convert(12'haaa, 1'b0, 1'b0, 1'b1);
        read_n <= 1'b0;
        repeat (6) @(posedge clk);
        check_drive(result_lines_oe, 12'hfff);
        read_n <= 1'b1;
        repeat (6) @(posedge clk);
        check_drive(result_lines_oe, 12'h000);
        select_n <= 1'b1;
        read_n <= 1'b0;
        repeat (6) @(posedge clk);
        check_drive(result_lines_oe, 12'h000);
        tally_and_finish;
    end
endmodule
